// [hdl/irq_vector_ctl.v]
// Interrupt vector, extended mode and prescaler control over AXI4-Lite.
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctl_defines.vh"

module irq_vector_ctl (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        ev_arb_lost,
    input  wire        ev_noack,
    input  wire        ev_reg_access_ready,
    input  wire        ev_rx_data_ready,
    input  wire        ev_slave_ack,
    input  wire        ev_buffer_to_shift,
    input  wire        ev_stop_detected,
    input  wire        ev_addressed_as_slave,
    input  wire        master_tx_active,
    input  wire        slave_tx_active,
    output reg         int_vector_irq,
    output reg         irq,
    output reg         abort_transfer,
    output reg         module_reset_release,
    output reg         module_clk_tick
);

    reg  [1:0]  extended_mode;
    reg  [7:0]  prescale_divisor;
    reg  [6:0]  int_status;
    reg  [6:0]  int_mask;
    reg  [6:0]  ev_status;
    reg  [6:0]  ev_mask;
    reg         have_aw;
    reg         have_w;
    reg  [7:0]  aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg  [6:0]  raw_events;
    reg  [6:0]  pend;
    reg  [6:0]  clear_onehot;
    reg  [2:0]  code;
    reg  [31:0] next_rdata;
    reg  [1:0]  next_rresp;
    wire        tick;
    wire        write_go;
    wire        read_go;
    wire        release_edge;
    wire        noack_stops;
    wire        tx_ready_ev;
    wire [6:0]  next_int_status;
    wire [6:0]  next_ev_status;
    wire        vector_read;
    wire        event_read;
    wire        reg_write;
    wire        wr_ext_mode;
    wire        wr_prescaler;
    wire        wr_mode_control;
    wire        wr_int_mask;
    wire        wr_ev_mask;
    genvar      g;
    integer     i;

    // ======================================================================
    // Event sources
    // ======================================================================
    // A stopping NACK also reports access-ready so software sees the end.
    assign noack_stops = ev_noack && master_tx_active
                         && !extended_mode[`EXT_IGNORE_NOACK_MODE_BIT];
    // Transmit-ready exists only while acting as slave transmitter.
    assign tx_ready_ev = slave_tx_active
        && (extended_mode[`EXT_COMPAT_BIT] ? ev_buffer_to_shift
                                            : ev_slave_ack);

    always @* begin
        raw_events    = 7'h00;
        raw_events[0] = ev_arb_lost;
        raw_events[1] = ev_noack && (!master_tx_active
                        || !extended_mode[`EXT_IGNORE_NOACK_MODE_BIT]);
        raw_events[2] = ev_reg_access_ready || noack_stops;
        raw_events[3] = ev_rx_data_ready;
        raw_events[4] = tx_ready_ev;
        raw_events[5] = ev_stop_detected;
        raw_events[6] = ev_addressed_as_slave;
    end

    // ======================================================================
    // Priority encoder
    // ======================================================================
    always @* begin
        pend         = int_status & int_mask;
        code         = `CODE_NONE;
        clear_onehot = 7'h00;
        // Scanning downward leaves the lowest pending code in place.
        for (i = `NUM_FLAGS - 1; i >= 0; i = i - 1) begin
            if (pend[i]) begin
                code         = i[2:0] + 3'h1;
                clear_onehot = 7'h01 << i;
            end
        end
    end

    // ======================================================================
    // Bus handshakes
    // ======================================================================
    // Ready drops after each handshake and returns once the answer is accepted, so
    // only one write and one read are ever outstanding.
    assign write_go    = have_aw && have_w && !s_axi_bvalid;
    assign read_go     = s_axi_arvalid && s_axi_arready;
    assign vector_read = read_go && s_axi_araddr == `OFS_INT_VECTOR;
    assign event_read  = read_go && s_axi_araddr == `OFS_EVENT_STATUS;

    // ======================================================================
    // Register write decode
    // ======================================================================
    // Only the low byte lane carries register bits, so it gates all writes.
    assign reg_write       = write_go && w_strb[0];
    assign wr_ext_mode     = reg_write && aw_addr == `OFS_EXT_MODE;
    assign wr_prescaler    = reg_write && aw_addr == `OFS_PRESCALER;
    assign wr_mode_control = reg_write && aw_addr == `OFS_MODE_CONTROL;
    assign wr_int_mask     = reg_write && aw_addr == `OFS_INT_MASK;
    assign wr_ev_mask      = reg_write && aw_addr == `OFS_EVENT_MASK;
    assign release_edge    = wr_mode_control
                             && w_data[`MODE_RESET_REL_BIT]
                             && !module_reset_release;

    // ======================================================================
    // Read data select
    // ======================================================================
    // Unmapped reads return zero with a slave error.
    always @* begin
        next_rresp = `RESP_OKAY;
        case (s_axi_araddr)
            `OFS_INT_VECTOR:   next_rdata = {29'h0000_0000, code};
            `OFS_EXT_MODE:     next_rdata = {30'h0000_0000, extended_mode};
            `OFS_PRESCALER:    next_rdata = {24'h00_0000, prescale_divisor};
            `OFS_MODE_CONTROL: next_rdata = {31'h0000_0000,
                                             module_reset_release};
            `OFS_INT_STATUS:   next_rdata = {25'h000_0000, int_status};
            `OFS_INT_MASK:     next_rdata = {25'h000_0000, int_mask};
            `OFS_EVENT_STATUS: next_rdata = {25'h000_0000, ev_status};
            `OFS_EVENT_MASK:   next_rdata = {25'h000_0000, ev_mask};
            default: begin
                next_rdata = 32'h0000_0000;
                next_rresp = `RESP_SLVERR;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            have_aw       <= 1'b0;
            have_w        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                have_aw       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                have_w       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (write_go) begin
                have_aw      <= 1'b0;
                have_w       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr)
                    `OFS_INT_VECTOR,
                    `OFS_EXT_MODE,
                    `OFS_PRESCALER,
                    `OFS_MODE_CONTROL,
                    `OFS_INT_STATUS,
                    `OFS_INT_MASK,
                    `OFS_EVENT_STATUS,
                    `OFS_EVENT_MASK: s_axi_bresp <= `RESP_OKAY;
                    default:         s_axi_bresp <= `RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Read channel
    // ======================================================================
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            // The vector code and its clear share one edge.
            if (read_go) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= next_rdata;
                s_axi_rresp   <= next_rresp;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Control registers
    // ======================================================================
    always @(posedge aclk) begin
        if (!aresetn) begin
            extended_mode        <= `RST_EXT_MODE;
            prescale_divisor     <= `RST_PRESCALER;
            module_reset_release <= 1'b0;
            int_mask             <= `RST_MASK;
            ev_mask              <= `RST_MASK;
        end else begin
            // Masks gate the interrupt lines, and int_mask also gates the vector code; flags keep collecting.
            if (wr_ext_mode) begin
                extended_mode <= w_data[1:0];
            end
            if (wr_prescaler) begin
                prescale_divisor <= w_data[7:0];
            end
            if (wr_mode_control) begin
                module_reset_release <= w_data[`MODE_RESET_REL_BIT];
            end
            if (wr_int_mask) begin
                int_mask <= w_data[6:0];
            end
            if (wr_ev_mask) begin
                ev_mask <= w_data[6:0];
            end
        end
    end

    // ======================================================================
    // Sticky flag bits
    // ======================================================================
    generate
        for (g = 0; g < `NUM_FLAGS; g = g + 1) begin : flag_bits
            // A new event in the clearing cycle wins over the clear.
            assign next_int_status[g] = raw_events[g]
                || (int_status[g] && !(vector_read && clear_onehot[g]));
            assign next_ev_status[g]  = raw_events[g]
                || (ev_status[g] && !event_read);
        end
    endgenerate

    // ======================================================================
    // Flags and interrupts
    // ======================================================================
    always @(posedge aclk) begin
        if (!aresetn) begin
            int_status     <= 7'h00;
            ev_status      <= 7'h00;
            int_vector_irq <= 1'b0;
            irq            <= 1'b0;
            abort_transfer <= 1'b0;
        end else begin
            int_status     <= next_int_status;
            ev_status      <= next_ev_status;
            int_vector_irq <= |(int_status & int_mask
                               & ~(vector_read ? clear_onehot : 7'h00));
            irq            <= |(ev_status & ev_mask);
            abort_transfer <= noack_stops;
        end
    end

    // ======================================================================
    // Module clock prescaler
    // ======================================================================
    // The divisor is copied only on the release edge, so later writes wait.
    clock_prescaler #(
        .W (`PSC_W)
    ) u_prescaler (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (module_reset_release),
        .load    (release_edge),
        .divisor (prescale_divisor),
        .tick    (tick)
    );

    // Registering the tick keeps every output on a flip-flop.
    always @(posedge aclk) begin
        if (!aresetn) begin
            module_clk_tick <= 1'b0;
        end else begin
            module_clk_tick <= tick;
        end
    end

endmodule // irq_vector_ctl

`default_nettype wire

// [hdl/irq_ctl_defines.vh]
// Register offsets, field positions, reset values and codes of the control block.
`ifndef IRQ_CTL_DEFINES_VH
`define IRQ_CTL_DEFINES_VH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define OFS_INT_VECTOR     8'h00
`define OFS_EXT_MODE       8'h04
`define OFS_PRESCALER      8'h08
`define OFS_MODE_CONTROL   8'h0C
`define OFS_INT_STATUS     8'h10
`define OFS_INT_MASK       8'h14
`define OFS_EVENT_STATUS   8'h18
`define OFS_EVENT_MASK     8'h1C

// ==========================================================================
// Field positions and widths
// ==========================================================================
`define EXT_COMPAT_BIT     0
`define EXT_IGNORE_NOACK_MODE_BIT     1
`define MODE_RESET_REL_BIT 0
`define CODE_W             3
`define NUM_FLAGS          7
`define PSC_W              8

// ==========================================================================
// Interrupt codes
// ==========================================================================
`define CODE_NONE          3'h0
`define CODE_ARB_LOST      3'h1
`define CODE_NOACK         3'h2
`define CODE_ACCESS_READY  3'h3
`define CODE_RX_READY      3'h4
`define CODE_TX_READY      3'h5
`define CODE_STOP          3'h6
`define CODE_SLAVE_ADDR    3'h7

// ==========================================================================
// Reset values
// ==========================================================================
`define RST_EXT_MODE       2'h1
`define RST_PRESCALER      8'h00
`define RST_MASK           7'h00

// ==========================================================================
// AXI responses
// ==========================================================================
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// [hdl/clock_prescaler.v]
// Module clock enable divider with a divisor captured at reset release.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctl_defines.vh"

module clock_prescaler #(
    parameter W = `PSC_W
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire         run,
    input  wire         load,
    input  wire [W-1:0] divisor,
    output reg          tick
);

    reg [W-1:0] active;
    reg [W-1:0] count;

    // ======================================================================
    // Divide by divisor plus one
    // ======================================================================
    always @(posedge aclk) begin
        if (!aresetn) begin
            active <= {W{1'b0}};
            count  <= {W{1'b0}};
            tick   <= 1'b0;
        end else begin
            if (load) begin
                active <= divisor;
                count  <= {W{1'b0}};
                tick   <= 1'b0;
            end else if (!run) begin
                count <= {W{1'b0}};
                tick  <= 1'b0;
            end else if (count >= active) begin
                count <= {W{1'b0}};
                tick  <= 1'b1;
            end else begin
                count <= count + {{(W-1){1'b0}}, 1'b1};
                tick  <= 1'b0;
            end
        end
    end

endmodule // clock_prescaler

`default_nettype wire

// [tb/bus_engine_model.sv]
// Bus engine stand-in that turns an event number into one event pulse.
`timescale 1ns/1ps
`default_nettype none
module bus_engine_model (
    input  wire logic [3:0] ev_sel,
    output logic            ev_arb_lost,
    output logic            ev_noack,
    output logic            ev_reg_access_ready,
    output logic            ev_rx_data_ready,
    output logic            ev_slave_ack,
    output logic            ev_buffer_to_shift,
    output logic            ev_stop_detected,
    output logic            ev_addressed_as_slave
);
// ==================
// Event decode
// ==================
// Each selection lasts one clock, so every event is a one-cycle pulse.
assign ev_arb_lost           = (ev_sel == 4'h1);
assign ev_noack              = (ev_sel == 4'h2);
assign ev_reg_access_ready   = (ev_sel == 4'h3);
assign ev_rx_data_ready      = (ev_sel == 4'h4);
assign ev_slave_ack          = (ev_sel == 4'h5);
assign ev_buffer_to_shift    = (ev_sel == 4'h6);
assign ev_stop_detected      = (ev_sel == 4'h7);
assign ev_addressed_as_slave = (ev_sel == 4'h8);
endmodule // bus_engine_model
`default_nettype wire

// [tb/irq_ctl_chk_assertions.sv]
// Concurrent checks on the control block ports.
`timescale 1ns/1ps
`default_nettype none
module irq_ctl_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        ev_noack,
    input wire logic        master_tx_active,
    input wire logic        abort_transfer,
    input wire logic        module_reset_release,
    input wire logic        module_clk_tick
);
// ==================
// Assertions
// ==================
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
upper_zero_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
abort_cause_a: assert property (
    abort_transfer |-> $past(ev_noack) && $past(master_tx_active))
    else $error("abort without a master transmit noack");
tick_gate_a: assert property (
    module_clk_tick |-> $past(module_reset_release, 2))
    else $error("module tick while held in reset");
bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
read_latency_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
write_latency_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
busy_ready_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while response pending");
endmodule // irq_ctl_chk
bind irq_vector_ctl irq_ctl_chk chk (.*);
`default_nettype wire

// [tb/irq_vector_ctl_bench.sv]
// Self-checking bench for the interrupt vector and prescaler block.
`timescale 1ns/1ps
`default_nettype none
module irq_vector_ctl_bench;
// ==================
// Signals
// ==================
logic        aclk = 1'b0;
logic        aresetn = 1'b0;
logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
logic [31:0] s_axi_wdata = 32'h0000_0000;
logic [3:0]  s_axi_wstrb = 4'hf;
logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
logic        s_axi_rvalid;
logic [1:0]  s_axi_bresp, s_axi_rresp, b_resp;
logic [31:0] s_axi_rdata, rd_data;
logic        ev_arb_lost, ev_noack, ev_reg_access_ready, ev_rx_data_ready;
logic        ev_slave_ack, ev_buffer_to_shift, ev_stop_detected;
logic        ev_addressed_as_slave, int_vector_irq, irq, abort_transfer;
logic        module_reset_release, module_clk_tick;
logic        master_tx_active = 1'b0, slave_tx_active = 1'b0;
logic [3:0]  ev_sel = 4'h0;
int          error_cnt = 0, cmp_count = 0, cyc = 0, ticks = 0, aborts = 0;
irq_vector_ctl uut (.*);
bus_engine_model partner (.*);
always #2 aclk = ~aclk;
always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (module_clk_tick) ticks <= ticks + 1;
    if (abort_transfer) aborts <= aborts + 1;
    if (cyc == 20000) begin
        error_cnt++;
        results();
    end
end
// ==================
// Tasks
// ==================
task results();
    $display("comparisons %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
        $display("SIMULATION PASSED");
    end else begin
        $display("SIMULATION FAILED");
    end
    $finish;
endtask
task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
        error_cnt++;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    b_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
endtask
task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    s_axi_rready <= 1'b0;
endtask
task rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_data, exp);
endtask
task ev(input logic [3:0] n);
    ev_sel <= n;
    @(posedge aclk);
    ev_sel <= 4'h0;
    repeat (3) @(posedge aclk);
endtask
task t_regs();
    rc(8'h04, 32'h0000_0001);
    rc(8'h00, 32'h0000_0000);
    wr(8'h04, 32'hffff_ffff);
    chk({30'h0000_0000, b_resp}, 32'h0000_0000);
    rc(8'h04, 32'h0000_0003);
    wr(8'h08, 32'hffff_ffff);
    rc(8'h08, 32'h0000_00ff);
    rd(8'h20);
    chk({30'h0000_0000, s_axi_rresp}, 32'h0000_0002);
    chk(rd_data, 32'h0000_0000);
    wr(8'h24, 32'h0000_0001);
    chk({30'h0000_0000, b_resp}, 32'h0000_0002);
endtask
task t_prio();
    logic [31:0] codes [5];
    codes = '{1, 3, 4, 6, 7};
    wr(8'h14, 32'h0000_007f);
    ev(4'h8);
    ev(4'h7);
    ev(4'h3);
    ev(4'h4);
    ev(4'h1);
    chk({31'h0000_0000, int_vector_irq}, 32'h0000_0001);
    // The vector is drained before any further traffic.
    foreach (codes[i]) begin
        rc(8'h00, codes[i]);
        repeat (2) @(posedge aclk);
        chk({31'h0000_0000, int_vector_irq}, {31'h0000_0000, i < 4});
    end
    rc(8'h00, 32'h0000_0000);
endtask
task t_nack();
    int a0;
    a0 = aborts;
    wr(8'h04, 32'h0000_0000);
    master_tx_active <= 1'b1;
    ev(4'h2);
    chk(aborts - a0, 1);
    rc(8'h00, 32'h0000_0002);
    rc(8'h00, 32'h0000_0003);
    wr(8'h04, 32'h0000_0002);
    ev(4'h2);
    chk(aborts - a0, 1);
    rc(8'h00, 32'h0000_0000);
    master_tx_active <= 1'b0;
endtask
task t_txrdy();
    slave_tx_active <= 1'b1;
    wr(8'h04, 32'h0000_0000);
    ev(4'h6);
    rc(8'h00, 32'h0000_0000);
    ev(4'h5);
    rc(8'h00, 32'h0000_0005);
    wr(8'h04, 32'h0000_0001);
    ev(4'h5);
    rc(8'h00, 32'h0000_0000);
    ev(4'h6);
    rc(8'h00, 32'h0000_0005);
    slave_tx_active <= 1'b0;
    ev(4'h5);
    ev(4'h6);
    rc(8'h00, 32'h0000_0000);
endtask
task t_evstat();
    rc(8'h18, 32'h0000_007f);
    rc(8'h18, 32'h0000_0000);
    wr(8'h1c, 32'h0000_007f);
    ev(4'h4);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    rc(8'h18, 32'h0000_0008);
    repeat (2) @(posedge aclk);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    rc(8'h00, 32'h0000_0004);
endtask
task cnt_ticks(input int exp);
    int t0;
    repeat (4) @(posedge aclk);
    t0 = ticks;
    repeat (40) @(posedge aclk);
    chk(ticks - t0, exp);
endtask
task t_psc();
    wr(8'h08, 32'h0000_0003);
    cnt_ticks(0);
    wr(8'h0c, 32'h0000_0001);
    chk({31'h0000_0000, module_reset_release}, 32'h0000_0001);
    cnt_ticks(10);
    wr(8'h08, 32'h0000_0000);
    cnt_ticks(10);
    wr(8'h0c, 32'h0000_0000);
    chk({31'h0000_0000, module_reset_release}, 32'h0000_0000);
    wr(8'h0c, 32'h0000_0001);
    cnt_ticks(40);
endtask
// ==================
// Main sequence
// ==================
initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_prio();
    t_nack();
    t_txrdy();
    t_evstat();
    t_psc();
    results();
end
endmodule // irq_vector_ctl_bench
`default_nettype wire
